// [rtl/spc_pkg.sv]
// Constants, mode codes and state types for the sleep power controller.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
package spc_pkg;

  // Width of the sleep mode select field.
  localparam int MODE_W = 3;

  // Width of the regulator power select field.
  localparam int VREG_W = 3;

  // Sleep mode select codes.
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_PDOWN   = 3'h2;

  // Regulator power select codes.
  localparam logic [2:0] VREG_AUTO = 3'h0;
  localparam logic [2:0] VREG_FULL = 3'h1;

  // Normal wake-up length in core clock cycles.
  localparam int WAKE_CYCLES = 6;

  // Extra start-up cycles added outside Idle when the regulator is not in full setting.
  localparam int STARTUP_CYCLES = 16;

  // Width of the wake-up counter.
  localparam int WCNT_W = 5;

  // Reset value of the sleep mode select field.
  localparam logic [2:0] MODE_RST = 3'h0;

  // Controller states.
  typedef enum logic [1:0] {
    SPC_ACTIVE,
    SPC_SLEEP,
    SPC_WAKE
  } spc_state_e;

  // Decoded sleep mode.
  typedef enum logic [1:0] {
    SPC_M_IDLE,
    SPC_M_STANDBY,
    SPC_M_PDOWN,
    SPC_M_RESERVED
  } spc_mode_e;

endpackage : spc_pkg

// [rtl/spc_sleep_ctrl.sv]
// Sleep power controller: Active, Idle, Standby and Power-Down handling.
// Assumes the CPU pulses sleep_instr for one cycle and that all wake
// sources and configuration bits are synchronous to core_clk.
// Operation
// [R1] One Active mode, three sleep modes.
// [R2] Sleep entered only from Active; CPU halted.
// [R3] Interrupt wake runs service routine, then resumes.
// [R4] Reset during sleep restarts from reset vector.
// [R5] Registers and memories keep contents while sleeping.
// [R6] Software enables wake interrupts before sleeping.
// [R7] Sleep needs mode, enable, then sleep instruction.
// [R8] Auto regulator low power only sleeping, 32k only.
// [R9] Full regulator setting keeps full drive always.
// [R10] Standby peripheral runs only with run-in-standby.
// [R11] Power-Down keeps watchdog, wakeup timer, oscillators.
// [R12] Power-Down wakes: brownout, voltage, timer, pin, match, logic.
// [R13] Software disables match and logic before hot-leak.
// [R14] Standby counter needs run bit; Power-Down timer only.
// [R15] Logic unit wakes only on asynchronous path; code checks this in Power-Down only, not Standby.
// [R16] Pins must use asynchronous sensing for Power-Down.
// [R17] Standby clocks run only for run-in-standby users.
// [R18] Wake set depends on mode; Idle wakes all.
// [R19] Mode codes: 0 Idle, 1 Standby, 2 Power-Down.
// [R20] Regulator codes: 0 automatic, 1 full drive.
// [R21] Wake-up takes six cycles plus start-up.
// [R22] Debug break while sleeping forces Active.
// [R23] Sleep with enable clear or reserved mode: no-op.
`timescale 1ns/1ps

module spc_sleep_ctrl
  import spc_pkg::*;
#(
  parameter int NPERIPH = 8  // Number of peripherals with a run-in-standby bit.
) (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic [MODE_W-1:0]  sleep_mode_select,
  input  wire logic               sleep_enable_bit,
  input  wire logic [VREG_W-1:0]  regulator_power_select,
  input  wire logic               hot_leak_reduce_enable,
  input  wire logic               sleep_instr,
  input  wire logic [NPERIPH-1:0] run_in_standby,
  input  wire logic               rtc_run_in_standby,
  input  wire logic               main_clk_user_standby,
  input  wire logic               clu_clk_user_standby,
  input  wire logic               only_low_freq_internal_osc,
  input  wire logic               irq_any,
  input  wire logic               irq_pin,
  input  wire logic               irq_brownout_detector,
  input  wire logic               irq_io_voltage_monitor,
  input  wire logic               irq_periodic_wakeup_timer,
  input  wire logic               irq_rtc,
  input  wire logic               irq_two_wire_port_match,
  input  wire logic               irq_usart_sof,
  input  wire logic               irq_configurable_logic_unit,
  input  wire logic [1:0]         lut_filter_select,
  input  wire logic [1:0]         lut_edge_detect,
  input  wire logic               debug_break,
  output logic                    cpu_halt,
  output logic                    irq_wake,
  output logic                    in_sleep,
  output logic [1:0]              active_mode,
  output logic [NPERIPH-1:0]      periph_clk_en,
  output logic                    rtc_run,
  output logic                    watchdog_timer_run,
  output logic                    periodic_wakeup_timer_run,
  output logic                    main_clk_src_en,
  output logic                    clu_clk_src_en,
  output logic                    osc_watchdog_brownout_en,
  output logic                    regulator_low_power,
  output logic                    hot_leak_active
);

  spc_state_e        state_q;     // Controller state.
  spc_mode_e         mode_q;      // Mode latched at sleep entry.
  logic [WCNT_W-1:0] wcnt_q;      // Wake-up cycles remaining.
  logic              irq_wake_q;  // Wake came from an interrupt.
  logic              wake_src;    // Qualified wake event this cycle.
  logic              sleep_ok;    // Sleep instruction is legal now.
  logic              clu_async;   // Logic unit path is asynchronous.
  spc_mode_e         req_mode;    // Decoded requested mode.

  // Decoding of the mode field; reserved codes never enter sleep.
  function automatic spc_mode_e decode_mode(input logic [MODE_W-1:0] code);
    case (code)
      MODE_IDLE:    decode_mode = SPC_M_IDLE;     // [R19]
      MODE_STANDBY: decode_mode = SPC_M_STANDBY;  // [R19]
      MODE_PDOWN:   decode_mode = SPC_M_PDOWN;    // [R19]
      default:       decode_mode = SPC_M_RESERVED;
    endcase
  endfunction

  // In Power-Down the logic unit only wakes when neither filter nor edge detect is used.
  assign clu_async = (lut_filter_select == 2'h0) && (lut_edge_detect == 2'h0); // [R15]
  assign req_mode  = decode_mode(sleep_mode_select);

  // Legal sleep request: enable set, mode valid, controller Active.
  assign sleep_ok = sleep_instr && sleep_enable_bit && (req_mode != SPC_M_RESERVED)
                    && (state_q == SPC_ACTIVE); // [R2] [R7] [R23]

  // Mode-dependent wake qualification. In Power-Down, hot-leak enable drops the match and
  // logic unit sources since they cannot operate under it.
  always_comb begin
    case (mode_q)
      SPC_M_IDLE: begin
        wake_src = irq_any; // [R18]
      end
      SPC_M_STANDBY: begin
        wake_src = irq_pin | irq_brownout_detector | irq_io_voltage_monitor
                 | (irq_rtc & rtc_run_in_standby) | irq_two_wire_port_match
                 | irq_configurable_logic_unit | irq_usart_sof; // [R14] [R18]
      end
      SPC_M_PDOWN: begin
        wake_src = irq_pin | irq_brownout_detector | irq_io_voltage_monitor
                 | irq_periodic_wakeup_timer
                 | (~hot_leak_reduce_enable
                    & (irq_two_wire_port_match
                       | (irq_configurable_logic_unit & clu_async))); // [R12] [R15]
      end
      default: begin
        wake_src = 1'b0;
      end
    endcase
  end

  // Main state machine. Reset always lands in Active so the CPU restarts
  // from its reset vector; register contents are never touched here. [R5]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= SPC_ACTIVE; // [R4]
    end else begin
      case (state_q)
        SPC_ACTIVE: begin
          if (sleep_ok) begin
            state_q <= SPC_SLEEP; // [R7]
          end
        end
        SPC_SLEEP: begin
          // Without an enabled wake source or a debug break the controller simply stays here.
          if (wake_src || debug_break) begin
            state_q <= SPC_WAKE; // [R22]
          end
        end
        SPC_WAKE: begin
          if (wcnt_q == WCNT_W'(1)) begin
            state_q <= SPC_ACTIVE; // [R21]
          end
        end
        default: begin
          state_q <= SPC_ACTIVE;
        end
      endcase
    end
  end

  // Latch the mode at entry so later field writes cannot alter it mid-sleep.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= SPC_M_IDLE;
    end else if (sleep_ok) begin
      mode_q <= req_mode; // [R1]
    end
  end

  // Wake-up counter: six cycles, plus start-up outside Idle unless the regulator is in full setting.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wcnt_q <= '0;
    end else if (state_q == SPC_SLEEP && (wake_src || debug_break)) begin
      if (mode_q == SPC_M_IDLE || regulator_power_select == VREG_FULL) begin
        wcnt_q <= WCNT_W'(WAKE_CYCLES); // [R21] [R9]
      end else begin
        wcnt_q <= WCNT_W'(WAKE_CYCLES + STARTUP_CYCLES); // [R21]
      end
    end else if (state_q == SPC_WAKE) begin
      wcnt_q <= wcnt_q - WCNT_W'(1);
    end
  end

  // Interrupt-caused wake: CPU is told to take the service routine first.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_wake_q <= 1'b0;
    end else if (state_q == SPC_SLEEP && wake_src) begin
      irq_wake_q <= 1'b1; // [R3]
    end else if (state_q == SPC_SLEEP && debug_break) begin
      irq_wake_q <= 1'b0;
    end
  end

  // Registered outputs toward CPU and clock/peripheral gating.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_halt                  <= 1'b0;
      irq_wake                  <= 1'b0;
      in_sleep                  <= 1'b0;
      active_mode               <= 2'h0;
      periph_clk_en             <= '1;
      rtc_run                   <= 1'b1;
      watchdog_timer_run        <= 1'b1;
      periodic_wakeup_timer_run <= 1'b1;
      main_clk_src_en           <= 1'b1;
      clu_clk_src_en            <= 1'b1;
      osc_watchdog_brownout_en  <= 1'b1;
      regulator_low_power       <= 1'b0;
      hot_leak_active           <= 1'b0;
    end else begin
      cpu_halt    <= (state_q != SPC_ACTIVE); // [R2]
      irq_wake    <= (state_q == SPC_WAKE) && (wcnt_q == WCNT_W'(1)) && irq_wake_q; // [R3]
      in_sleep    <= (state_q == SPC_SLEEP);
      active_mode <= (state_q == SPC_SLEEP) ? (2'h1 + 2'(mode_q)) : 2'h0; // [R1]
      watchdog_timer_run        <= 1'b1; // [R11]
      periodic_wakeup_timer_run <= 1'b1; // [R11]
      osc_watchdog_brownout_en  <= 1'b1; // [R11]
      if (state_q == SPC_SLEEP && mode_q == SPC_M_STANDBY) begin
        periph_clk_en   <= run_in_standby;        // [R10]
        rtc_run         <= rtc_run_in_standby;    // [R14]
        main_clk_src_en <= main_clk_user_standby; // [R17]
        clu_clk_src_en  <= clu_clk_user_standby;  // [R17]
      end else if (state_q == SPC_SLEEP && mode_q == SPC_M_PDOWN) begin
        periph_clk_en   <= '0;
        rtc_run         <= 1'b0; // [R14]
        main_clk_src_en <= 1'b0;
        clu_clk_src_en  <= 1'b0;
      end else begin
        periph_clk_en   <= '1;
        rtc_run         <= 1'b1;
        main_clk_src_en <= 1'b1;
        clu_clk_src_en  <= 1'b1;
      end
      // Low-current regulator only in auto setting, asleep, 32k alone.
      regulator_low_power <= (regulator_power_select == VREG_AUTO)
                             && (state_q == SPC_SLEEP)
                             && only_low_freq_internal_osc; // [R8] [R9] [R20]
      hot_leak_active <= hot_leak_reduce_enable && (state_q == SPC_SLEEP)
                         && (mode_q == SPC_M_PDOWN)
                         && (regulator_power_select == VREG_AUTO);
    end
  end

  // A legal sleep request halts the CPU on the second edge after it.
  AST_ENTER_HALT: assert property (@(posedge core_clk) disable iff (srst)
    sleep_ok |=> ##1 cpu_halt) // [R2]
    else $error("Sleep request did not halt the CPU.");

  // Illegal sleep requests leave the controller active.
  AST_NOOP: assert property (@(posedge core_clk) disable iff (srst)
    (sleep_instr && state_q == SPC_ACTIVE
     && (!sleep_enable_bit || req_mode == SPC_M_RESERVED)) |=> ##1 !cpu_halt) // [R23]
    else $error("Illegal sleep request entered sleep.");

  sequence s_wake_idle;
    state_q == SPC_SLEEP && mode_q == SPC_M_IDLE && irq_any;
  endsequence

  // Idle wake holds Wake for exactly six cycles, then returns to Active.
  AST_IDLE_WAKE: assert property (@(posedge core_clk) disable iff (srst)
    s_wake_idle |=> (state_q == SPC_WAKE) [*6] ##1 state_q == SPC_ACTIVE) // [R21] [R18]
    else $error("Idle wake-up length wrong.");

  // Debug break wakes any sleep mode.
  AST_DEBUG: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == SPC_SLEEP && debug_break) |=> state_q == SPC_WAKE) // [R22]
    else $error("Debug break did not wake.");

  // Power-Down ignores a plain interrupt with no qualified source.
  AST_PD_IGNORE: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == SPC_SLEEP && mode_q == SPC_M_PDOWN && !wake_src && !debug_break)
    |=> state_q == SPC_SLEEP) // [R12]
    else $error("Power-Down woke without a valid source.");

  // Standby gating follows run-in-standby bits.
  AST_STBY_GATE: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == SPC_SLEEP && mode_q == SPC_M_STANDBY && $stable(state_q))
    |=> periph_clk_en == $past(run_in_standby)) // [R10]
    else $error("Standby peripheral gating wrong.");

  // Full setting never lowers regulator drive.
  AST_FULL_REG: assert property (@(posedge core_clk) disable iff (srst)
    (regulator_power_select == VREG_FULL) |=> !regulator_low_power) // [R9]
    else $error("Regulator lowered in full setting.");

  // Auto setting lowers drive while sleeping on the 32k oscillator alone.
  AST_AUTO_REG: assert property (@(posedge core_clk) disable iff (srst)
    (regulator_power_select == VREG_AUTO && state_q == SPC_SLEEP
     && only_low_freq_internal_osc) |=> regulator_low_power) // [R8]
    else $error("Regulator not lowered in auto sleep.");

  // Watchdog and timer stay running whatever the mode.
  AST_PD_TIMERS: assert property (@(posedge core_clk) disable iff (srst)
    in_sleep |-> watchdog_timer_run && periodic_wakeup_timer_run
                 && osc_watchdog_brownout_en) // [R11]
    else $error("Watchdog or timer stopped in sleep.");

  // Power-Down stops the counter, every peripheral clock and both switched sources.
  AST_PD_GATE: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == SPC_SLEEP && mode_q == SPC_M_PDOWN) |=> !rtc_run && (periph_clk_en == '0)
      && !main_clk_src_en && !clu_clk_src_en) // [R14] [R17]
    else $error("Power-Down gating wrong.");

  // The interrupt-wake pulse marks the step from the last wake cycle to Active.
  AST_WAKE_PULSE: assert property (@(posedge core_clk) disable iff (srst)
    irq_wake |-> ($past(state_q) == SPC_WAKE) && (state_q == SPC_ACTIVE)) // [R3]
    else $error("Interrupt-wake pulse outside the wake exit.");

endmodule : spc_sleep_ctrl

// [tb/spc_cpu_model.sv]
// CPU and interrupt-controller partner that faces the sleep controller.
// Assumes the bench changes its requests just after the rising core_clk edge.
`timescale 1ns/1ps

module spc_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       sleep_req,
  input  wire logic       cpu_halt,
  input  wire logic [8:0] pend_req,
  output logic            sleep_instr,
  output logic [8:0]      irq_v
);
  // The sleep instruction is one cycle long and never issued while halted.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= sleep_req & ~cpu_halt & ~sleep_instr;
    end
  end

  // Every requested interrupt is presented as pending, with no enable masking.
  assign irq_v = pend_req;
endmodule // spc_cpu_model

// [tb/sleep_power_controller_test.sv]
// Self-checking bench for the sleep controller, driven through the CPU model.
// Assumes the design package and the partner model are compiled first.
`timescale 1ns/1ps

module sleep_power_controller_test;
  import spc_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, slp_en = 1'b0, hot = 1'b0, dbg = 1'b0, req = 1'b0;
  logic [2:0]  mode_sel = 3'h0, vreg_sel = 3'h0;
  logic [1:0]  lfs = 2'h0, led = 2'h0, active_mode;
  logic [7:0]  ris = 8'h00, pclk;
  logic        rtcr = 1'b0, mu = 1'b0, cu = 1'b0, olf = 1'b0, sleep_instr;
  logic [8:0]  pend = 9'h000, irq_v;
  logic        cpu_halt, irq_wake, in_sleep, rtc_run, wdog_run, wake_tmr_run;
  logic        main_en, clu_en, osc_en, reg_lp, hl_act;
  logic [31:0] lf = 32'h22A0;   // Random state, fixed start value.
  int          miscompares = 0;
  int          n_checks = 0;

  // 50 MHz clock.
  always #10 core_clk = ~core_clk;

  spc_cpu_model u_spc_cpu_model (.core_clk, .srst, .sleep_req(req), .cpu_halt, .pend_req(pend),
    .sleep_instr, .irq_v);

  spc_sleep_ctrl #(.NPERIPH(8)) u_spc_sleep_ctrl (.core_clk, .srst, .sleep_mode_select(mode_sel),
    .sleep_enable_bit(slp_en), .regulator_power_select(vreg_sel), .hot_leak_reduce_enable(hot),
    .sleep_instr, .run_in_standby(ris), .rtc_run_in_standby(rtcr), .main_clk_user_standby(mu),
    .clu_clk_user_standby(cu), .only_low_freq_internal_osc(olf), .irq_any(irq_v[0]),
    .irq_pin(irq_v[1]), .irq_brownout_detector(irq_v[2]), .irq_io_voltage_monitor(irq_v[3]),
    .irq_periodic_wakeup_timer(irq_v[4]), .irq_rtc(irq_v[5]),
    .irq_two_wire_port_match(irq_v[6]), .irq_usart_sof(irq_v[7]),
    .irq_configurable_logic_unit(irq_v[8]), .lut_filter_select(lfs), .lut_edge_detect(led),
    .debug_break(dbg), .cpu_halt, .irq_wake, .in_sleep, .active_mode, .periph_clk_en(pclk),
    .rtc_run, .watchdog_timer_run(wdog_run), .periodic_wakeup_timer_run(wake_tmr_run),
    .main_clk_src_en(main_en), .clu_clk_src_en(clu_en), .osc_watchdog_brownout_en(osc_en),
    .regulator_low_power(reg_lp), .hot_leak_active(hl_act));

  // Galois-free shift register; good enough to scatter configuration bits.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Inputs always move 1 ns after the edge, so no race with the design.
  task automatic step(input int k);
    repeat (k) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One sleep attempt: gating while asleep, a refused source if bad >= 0, then the wake.
  task automatic run(input logic [2:0] m, input logic [2:0] pm, input logic h,
                     input logic [1:0] lut, input int bad, input int wk, input logic goes);
    int   n;
    int   ext;
    logic seen;
    lf = lfsr(lf);
    {olf, cu, mu, rtcr, ris} = lf[11:0];
    if (bad == 5) rtcr = 1'b0;
    mode_sel = m;
    vreg_sel = pm;
    hot = h;
    lfs = {1'b0, lut[0]};
    led = {1'b0, lut[1]};
    slp_en = goes || m > 3'h2;
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(4);
    chk("cpu_halt", cpu_halt, goes);
    if (!goes) return;
    chk("in_sleep", in_sleep, 1'b1);
    chk("active_mode", active_mode, m + 3'h1);
    chk("periph_clk_en", pclk, m == 0 ? 8'hFF : m == 1 ? ris : 8'h00);
    chk("rtc_run", rtc_run, m == 0 || (m == 1 && rtcr));
    chk("always_on", {wdog_run, wake_tmr_run, osc_en}, 3'h7);
    chk("clk_src", {main_en, clu_en}, m == 0 ? 2'h3 : m == 1 ? {mu, cu} : 2'h0);
    chk("reg_low", reg_lp, pm == VREG_AUTO && olf);
    chk("hot_leak", hl_act, h && m == MODE_PDOWN && pm == VREG_AUTO);
    if (bad >= 0) begin
      pend[bad] = 1'b1;
      step(30);
      chk("stay_asleep", cpu_halt, 1'b1);
      pend = 9'h000;
    end
    if (wk < 0) dbg = 1'b1;
    else pend[wk] = 1'b1;
    seen = 1'b0;
    for (n = 1; n <= 60 && cpu_halt; n++) begin
      step(1);
      seen |= irq_wake;
    end
    if (cpu_halt) begin
      miscompares++;
      $display("[FAIL] wake_done expected 0 seen 1");
      summarize();
    end
    // Slow start-up applies outside Idle whenever the regulator setting is not full.
    // One step for the event to be sampled, one for the halt to drop.
    ext = (m != MODE_IDLE && pm != VREG_FULL) ? STARTUP_CYCLES : 0;
    chk("wake_cycles", n - 1, WAKE_CYCLES + 2 + ext);
    chk("irq_wake", seen, wk >= 0);
    pend = 9'h000;
    dbg = 1'b0;
    step(2);
  endtask

  initial begin
    step(5);
    srst = 1'b0;
    chk("reset_state", {cpu_halt, in_sleep, irq_wake, reg_lp, hl_act, active_mode}, 0);
    chk("reset_en", {pclk, rtc_run, wdog_run, wake_tmr_run, main_en, clu_en, osc_en}, 14'h3FFF);
    run(MODE_IDLE, VREG_AUTO, 1'b0, 2'h0, -1, 0, 1'b1);
    run(MODE_STANDBY, VREG_AUTO, 1'b0, 2'h0, 5, 7, 1'b1);
    run(MODE_STANDBY, VREG_FULL, 1'b0, 2'h0, -1, 2, 1'b1);
    run(MODE_PDOWN, VREG_AUTO, 1'b0, 2'h0, 7, 1, 1'b1);
    // Under hot-leak the match and logic sources stay quiet, as software must keep them.
    run(MODE_PDOWN, VREG_AUTO, 1'b1, 2'h0, 5, 4, 1'b1);
    run(MODE_PDOWN, VREG_FULL, 1'b0, 2'h1, 8, 3, 1'b1);
    run(MODE_PDOWN, VREG_FULL, 1'b0, 2'h2, 8, 2, 1'b1);
    run(MODE_PDOWN, VREG_AUTO, 1'b0, 2'h0, -1, 8, 1'b1);
    run(MODE_IDLE, VREG_FULL, 1'b0, 2'h0, -1, -1, 1'b1);
    run(MODE_STANDBY, 3'h2, 1'b0, 2'h0, -1, 1, 1'b1);
    run(MODE_STANDBY, VREG_AUTO, 1'b0, 2'h0, -1, 0, 1'b0);
    for (int m = 3; m < 8; m++) run(3'(m), VREG_AUTO, 1'b0, 2'h0, -1, 0, 1'b0);
    // A reset in mid-sleep must bring the block straight back to Active.
    run(MODE_IDLE, VREG_AUTO, 1'b0, 2'h0, -1, 0, 1'b1);
    slp_en = 1'b1;
    mode_sel = MODE_PDOWN;
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(4);
    srst = 1'b1;
    step(1);
    srst = 1'b0;
    chk("reset_wake", {cpu_halt, in_sleep, active_mode}, 4'h0);
    summarize();
  end
endmodule // sleep_power_controller_test
